// ===== hw/timer_ext_irq_pkg.sv
// Shared constants for the timer and external interrupt control block
package timer_ext_irq_pkg;

  // Register byte offsets
  localparam logic [7:0]  COUNT0_OFFSET     = 8'h80;
  localparam logic [7:0]  COUNT1_OFFSET     = 8'h84;
  localparam logic [7:0]  CTRL_OFFSET       = 8'h88;
  localparam logic [7:0]  IRQ_STATUS_OFFSET = 8'h90;
  localparam logic [7:0]  IRQ_MASK_OFFSET   = 8'h94;

  // Control register bit positions
  localparam int          DETECT_A_BIT      = 0;
  localparam int          FLAG_A_BIT        = 1;
  localparam int          DETECT_B_BIT      = 2;
  localparam int          FLAG_B_BIT        = 3;
  localparam int          RUN0_BIT          = 4;
  localparam int          OVF0_BIT          = 5;
  localparam int          RUN1_BIT          = 6;
  localparam int          OVF1_BIT          = 7;

  // Interrupt status and mask bit positions
  localparam int          EV_EXT_A_BIT      = 0;
  localparam int          EV_EXT_B_BIT      = 1;
  localparam int          EV_OVF0_BIT       = 2;
  localparam int          EV_OVF1_BIT       = 3;

  // Values after reset
  localparam logic [7:0]  CTRL_RESET        = 8'h00;
  localparam logic [3:0]  IRQ_STATUS_RESET  = 4'h0;
  localparam logic [3:0]  IRQ_MASK_RESET    = 4'h0;
  localparam logic [15:0] COUNT_RESET       = 16'h0000;

endpackage

// ===== hw/ext_irq_detect.sv
// Synchroniser and level or edge detector for one active-low interrupt pin
`timescale 1ns/1ps

module ext_irq_detect
  import timer_ext_irq_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  input  wire logic pin_n_i,
  input  wire logic edge_mode_i,
  output logic      detect_o
);

  logic sync_meta;
  logic sync_low;
  logic prev_low;
  logic next_sync_meta;
  logic next_sync_low;
  logic next_prev_low;

  always_comb begin
    next_sync_meta = ~pin_n_i;
    next_sync_low  = sync_meta;
    next_prev_low  = sync_low;
  end

  // Reset to not-asserted so a pin held low at release shows as a new edge
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync_meta <= 1'b0;
      sync_low  <= 1'b0;
      prev_low  <= 1'b0;
    end else begin
      sync_meta <= next_sync_meta;
      sync_low  <= next_sync_low;
      prev_low  <= next_prev_low;
    end
  end

  assign detect_o = edge_mode_i ? (sync_low & ~prev_low) : sync_low;

  chk_edge_needs_fall: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (edge_mode_i && detect_o) |-> $past(!sync_low) && sync_low)
    else $error("edge detect without a high to low transition");

endmodule

// ===== hw/run_counter.sv
// Free counter that advances only while its run bit is set
`timescale 1ns/1ps

module run_counter
  import timer_ext_irq_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  input  wire logic             run_i,
  output logic [WIDTH-1:0]      count_o,
  output logic                  carry_o
);

  logic [WIDTH-1:0] next_count;
  logic             next_carry;

  always_comb begin
    next_count = count_o;
    next_carry = 1'b0;
    if (run_i) begin
      {next_carry, next_count} = {1'b0, count_o} + {{WIDTH{1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_o <= WIDTH'(COUNT_RESET);
      carry_o <= 1'b0;
    end else begin
      count_o <= next_count;
      carry_o <= next_carry;
    end
  end

  chk_hold_when_stopped: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !run_i |=> $stable(count_o))
    else $error("count moved while stopped");

  chk_step_when_running: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    run_i |=> count_o == WIDTH'($past(count_o) + 1'b1))
    else $error("count did not step by one while running");

endmodule

// ===== hw/timer_ext_irq_control.sv
// Timer run and overflow control with two external interrupt requests, Avalon-MM slave
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps

// What this block does
// - Each external input is detected by level when its detect-type bit is 0 and by falling edge when it is 1.
// - Each of the two external inputs has its own request flag, set when its selected condition is seen.
// - A request flag clears by itself when the processor services that external interrupt, unless a detection or a software write of 1 sets it that cycle.
// - Software may set or clear a request flag only while that input's detect-type bit selects edge mode.
// - Each counter advances only while its run bit is 1 and holds its count while the bit is 0.
module timer_ext_irq_control
  import timer_ext_irq_pkg::*;
#(
  parameter int COUNT_WIDTH = 16
)
(
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [7:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        ext_irq_a_n_i,
  input  wire logic        ext_irq_b_n_i,
  input  wire logic        service_ext_a_i,
  input  wire logic        service_ext_b_i,
  input  wire logic        service_t0_i,
  input  wire logic        service_t1_i,
  output logic             ext_request_a_o,
  output logic             ext_request_b_o,
  output logic             counter0_overflow_o,
  output logic             counter1_overflow_o,
  output logic             irq_o
);

  logic [7:0]             timer_and_ext_irq_control;
  logic [7:0]             next_ctrl;
  logic [3:0]             irq_status;
  logic [3:0]             next_irq_status;
  logic [3:0]             irq_mask;
  logic [3:0]             next_irq_mask;
  logic                   ack;
  logic                   next_ack;
  logic [31:0]            next_readdata;
  logic [COUNT_WIDTH-1:0] count0;
  logic [COUNT_WIDTH-1:0] count1;
  logic                   carry0;
  logic                   carry1;
  logic                   detect_a;
  logic                   detect_b;
  logic                   acc_wr;
  logic                   acc_rd;
  logic                   wr_ctrl;
  logic                   wr_mask;
  logic                   rd_status;
  logic [3:0]             events;

  // Flag update: a hardware set always beats a service or software clear
  function automatic logic next_flag(input logic cur, input logic hw_set, input logic service,
                                     input logic sw_wr, input logic sw_val);
    logic result;
    result = sw_wr ? sw_val : (cur & ~service);
    return hw_set | result;
  endfunction

  ext_irq_detect u_detect_a (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .pin_n_i     (ext_irq_a_n_i),
    .edge_mode_i (timer_and_ext_irq_control[DETECT_A_BIT]),
    .detect_o    (detect_a)
  );

  ext_irq_detect u_detect_b (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .pin_n_i     (ext_irq_b_n_i),
    .edge_mode_i (timer_and_ext_irq_control[DETECT_B_BIT]),
    .detect_o    (detect_b)
  );

  run_counter #(
    .WIDTH (COUNT_WIDTH)
  ) u_counter0 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .run_i      (timer_and_ext_irq_control[RUN0_BIT]),
    .count_o    (count0),
    .carry_o    (carry0)
  );

  run_counter #(
    .WIDTH (COUNT_WIDTH)
  ) u_counter1 (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .run_i      (timer_and_ext_irq_control[RUN1_BIT]),
    .count_o    (count1),
    .carry_o    (carry1)
  );

  // Bus slave: one wait cycle per access; the access completes on the ack cycle
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign acc_wr            = avs_write_i & ack;
  assign acc_rd            = avs_read_i & ack;
  assign wr_ctrl           = acc_wr & avs_byteenable_i[0] & (avs_address_i == CTRL_OFFSET);
  assign wr_mask           = acc_wr & avs_byteenable_i[0] & (avs_address_i == IRQ_MASK_OFFSET);
  assign rd_status         = acc_rd & (avs_address_i == IRQ_STATUS_OFFSET);

  always_comb begin
    next_ack      = (avs_read_i | avs_write_i) & ~ack;
    next_readdata = avs_readdata_o;
    if (avs_read_i && !ack) begin
      unique case (avs_address_i)
        COUNT0_OFFSET:     next_readdata = 32'(count0);
        COUNT1_OFFSET:     next_readdata = 32'(count1);
        CTRL_OFFSET:       next_readdata = {24'h000000, timer_and_ext_irq_control};
        IRQ_STATUS_OFFSET: next_readdata = {28'h0000000, irq_status};
        IRQ_MASK_OFFSET:   next_readdata = {28'h0000000, irq_mask};
        default:           next_readdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ack            <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack            <= next_ack;
      avs_readdata_o <= next_readdata;
    end
  end

  // Control register next state
  always_comb begin
    next_ctrl = timer_and_ext_irq_control;
    if (wr_ctrl) begin
      next_ctrl[DETECT_A_BIT] = avs_writedata_i[DETECT_A_BIT];
      next_ctrl[DETECT_B_BIT] = avs_writedata_i[DETECT_B_BIT];
      next_ctrl[RUN0_BIT]     = avs_writedata_i[RUN0_BIT];
      next_ctrl[RUN1_BIT]     = avs_writedata_i[RUN1_BIT];
    end
    next_ctrl[FLAG_A_BIT] = next_flag(timer_and_ext_irq_control[FLAG_A_BIT], detect_a, service_ext_a_i,
                                      wr_ctrl & timer_and_ext_irq_control[DETECT_A_BIT],
                                      avs_writedata_i[FLAG_A_BIT]);
    next_ctrl[FLAG_B_BIT] = next_flag(timer_and_ext_irq_control[FLAG_B_BIT], detect_b, service_ext_b_i,
                                      wr_ctrl & timer_and_ext_irq_control[DETECT_B_BIT],
                                      avs_writedata_i[FLAG_B_BIT]);
    next_ctrl[OVF0_BIT]   = next_flag(timer_and_ext_irq_control[OVF0_BIT], carry0, service_t0_i,
                                      wr_ctrl, avs_writedata_i[OVF0_BIT]);
    next_ctrl[OVF1_BIT]   = next_flag(timer_and_ext_irq_control[OVF1_BIT], carry1, service_t1_i,
                                      wr_ctrl, avs_writedata_i[OVF1_BIT]);
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      timer_and_ext_irq_control <= CTRL_RESET;
    end else begin
      timer_and_ext_irq_control <= next_ctrl;
    end
  end

  // Sticky event status; a read clears only what it returned, so late events survive
  always_comb begin
    events                  = 4'h0;
    events[EV_EXT_A_BIT]    = detect_a;
    events[EV_EXT_B_BIT]    = detect_b;
    events[EV_OVF0_BIT]     = carry0;
    events[EV_OVF1_BIT]     = carry1;
    next_irq_status         = irq_status;
    if (rd_status) begin
      next_irq_status = irq_status & ~avs_readdata_o[3:0];
    end
    next_irq_status = next_irq_status | events;
    next_irq_mask   = wr_mask ? avs_writedata_i[3:0] : irq_mask;
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_status <= IRQ_STATUS_RESET;
      irq_mask   <= IRQ_MASK_RESET;
    end else begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  assign irq_o               = |(irq_status & irq_mask);
  assign ext_request_a_o     = timer_and_ext_irq_control[FLAG_A_BIT];
  assign ext_request_b_o     = timer_and_ext_irq_control[FLAG_B_BIT];
  assign counter0_overflow_o = timer_and_ext_irq_control[OVF0_BIT];
  assign counter1_overflow_o = timer_and_ext_irq_control[OVF1_BIT];

  chk_level_sets_flag: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (!timer_and_ext_irq_control[DETECT_A_BIT] && detect_a) ##1 detect_a |-> ext_request_a_o)
    else $error("level request a not held while input low");

  chk_detect_sets_b: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    detect_b |=> ext_request_b_o)
    else $error("request b not set after detection");

  chk_service_clears_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ext_request_a_o && service_ext_a_i && !detect_a && !wr_ctrl) |=> !ext_request_a_o)
    else $error("request a not cleared by service");

  chk_sw_write_level: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wr_ctrl && !timer_and_ext_irq_control[DETECT_B_BIT] && !detect_b && !service_ext_b_i)
      |=> ext_request_b_o == $past(ext_request_b_o))
    else $error("software changed request b in level mode");

  chk_sw_write_edge: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wr_ctrl && timer_and_ext_irq_control[DETECT_A_BIT] && !detect_a)
      |=> ext_request_a_o == $past(avs_writedata_i[FLAG_A_BIT]))
    else $error("software write to request a ignored in edge mode");

  chk_stop_freezes: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (!timer_and_ext_irq_control[RUN1_BIT] && !wr_ctrl) [*3] |-> $stable(count1))
    else $error("counter 1 moved while stopped");

  chk_carry_sets_ovf: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    carry0 |=> counter0_overflow_o ##0 irq_status[EV_OVF0_BIT])
    else $error("carry did not raise overflow 0");

  chk_service_clears_ovf: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (service_t1_i && !carry1 && !wr_ctrl) |=> !counter1_overflow_o)
    else $error("overflow 1 not cleared by service");

  chk_bus_one_wait: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    ((avs_read_i || avs_write_i) && !ack) |-> avs_waitrequest_o ##1 !avs_waitrequest_o)
    else $error("access not answered after one wait cycle");

  chk_idle_no_wait: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
    else $error("waitrequest raised with no request");

  chk_readdata_holds: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !(avs_read_i && !ack) |=> $stable(avs_readdata_o))
    else $error("read data changed outside a read");

  chk_ctrl_read_value: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (avs_read_i && !ack && avs_address_i == CTRL_OFFSET)
      |=> avs_readdata_o == {24'h000000, $past(timer_and_ext_irq_control)})
    else $error("control read returned a wrong value");

  chk_mask_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_mask |=> irq_mask == $past(avs_writedata_i[3:0]))
    else $error("mask write did not land");

  // Status bits are sticky: only a status read may drop them
  chk_status_sticky: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !rd_status |=> (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("status bit dropped without a read");

  chk_status_event: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (events != 4'h0) |=> (irq_status & $past(events)) == $past(events))
    else $error("event did not set its status bit");

  chk_status_read_clear: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (rd_status && events == 4'h0) |=> irq_status == ($past(irq_status) & ~$past(avs_readdata_o[3:0])))
    else $error("status read did not clear returned bits");

  chk_detect_sets_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    detect_a |=> ext_request_a_o)
    else $error("request a not set after detection");

  chk_service_clears_b: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (ext_request_b_o && service_ext_b_i && !detect_b && !wr_ctrl) |=> !ext_request_b_o)
    else $error("request b not cleared by service");

  chk_sw_write_edge_b: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wr_ctrl && timer_and_ext_irq_control[DETECT_B_BIT] && !detect_b)
      |=> ext_request_b_o == $past(avs_writedata_i[FLAG_B_BIT]))
    else $error("software write to request b ignored in edge mode");

  chk_sw_write_level_a: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wr_ctrl && !timer_and_ext_irq_control[DETECT_A_BIT] && !detect_a && !service_ext_a_i)
      |=> ext_request_a_o == $past(ext_request_a_o))
    else $error("software changed request a in level mode");

  chk_run_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_ctrl |=> timer_and_ext_irq_control[RUN0_BIT] == $past(avs_writedata_i[RUN0_BIT]))
    else $error("run bit 0 write did not land");

  chk_detect_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    wr_ctrl |=> timer_and_ext_irq_control[DETECT_A_BIT] == $past(avs_writedata_i[DETECT_A_BIT]))
    else $error("detect type a write did not land");

  // Overflow bits stay software-writable so a handler can clear them without a service pulse
  chk_ovf_sw_write: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (wr_ctrl && !carry1) |=> counter1_overflow_o == $past(avs_writedata_i[OVF1_BIT]))
    else $error("overflow 1 write did not land");

  chk_carry_sets_ovf1: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    carry1 |=> counter1_overflow_o ##0 irq_status[EV_OVF1_BIT])
    else $error("carry did not raise overflow 1");

  chk_service_clears_ovf0: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (service_t0_i && !carry0 && !wr_ctrl) |=> !counter0_overflow_o)
    else $error("overflow 0 not cleared by service");

endmodule

// ===== verification/irq_partner.sv
// Behavioural model of the external interrupt sources and the CPU vectoring pulses
`timescale 1ns/1ps

module irq_partner (
  input  wire logic  core_clk_i,
  input  wire logic  rstn_i,
  output logic       ext_irq_a_n_o,
  output logic       ext_irq_b_n_o,
  output logic [3:0] service_o
);
  logic [1:0] pin_level;

  // Pins idle high as if pulled up, so a released source never reads low
  initial begin
    pin_level = 2'b11;
    service_o = 4'h0;
  end

  assign ext_irq_a_n_o = pin_level[0];
  assign ext_irq_b_n_o = pin_level[1];

  task automatic set_pin(input int idx, input logic level);
    pin_level[idx] <= level;
  endtask

  // vectoring pulse
  // One cycle wide: index 0 ext a, 1 ext b, 2 timer 0, 3 timer 1
  task automatic pulse(input int idx);
    service_o[idx] <= 1'b1;
    @(posedge core_clk_i);
    service_o[idx] <= 1'b0;
    @(posedge core_clk_i);
  endtask
endmodule

// ===== verification/tb.sv
// Self-checking bench for the timer and external interrupt control block
`timescale 1ns/1ps

module tb
  import timer_ext_irq_pkg::*;
;
  logic        core_clk_i;
  logic        rstn_i;
  logic [7:0]  avs_address_i;
  logic        avs_read_i;
  logic        avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic        pin_a_n;
  logic        pin_b_n;
  logic [3:0]  service;
  logic [3:0]  be;
  logic [4:0]  outs;
  logic [31:0] rd;
  logic [31:0] c1;
  int          miscompares;
  int          total_checks;

  timer_ext_irq_control #(.COUNT_WIDTH(16)) u_timer_ext_irq_control (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ext_irq_a_n_i(pin_a_n), .ext_irq_b_n_i(pin_b_n), .service_ext_a_i(service[0]),
    .service_ext_b_i(service[1]), .service_t0_i(service[2]), .service_t1_i(service[3]),
    .ext_request_a_o(outs[0]), .ext_request_b_o(outs[1]), .counter0_overflow_o(outs[2]),
    .counter1_overflow_o(outs[3]), .irq_o(outs[4]));

  irq_partner u_irq_partner (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .ext_irq_a_n_o(pin_a_n),
    .ext_irq_b_n_o(pin_b_n), .service_o(service));

  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic report(input logic [31:0] got, input logic [31:0] exp);
    miscompares++;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) report(got, exp);
  endtask

  // Outputs are looked at mid-cycle, where they are settled
  task automatic cmp_bit(input int idx, input logic exp);
    @(negedge core_clk_i);
    total_checks++;
    if (outs[idx] !== exp) report({31'h0, outs[idx]}, {31'h0, exp});
    @(posedge core_clk_i);
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // Holds the request until waitrequest is seen low, releases at that edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] d);
    int n;
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    avs_writedata_i <= {24'h000000, wd};
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) report(32'h0, 32'h1);
    d = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, rd);
    cmp_word(rd, exp);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    bus(1'b1, a, wd, rd);
  endtask

  task automatic wait_flag(input int idx, input int lim);
    int n;
    n = 0;
    do begin
      @(negedge core_clk_i);
      n++;
    end while (outs[idx] !== 1'b1 && n < lim);
    if (n >= lim) report({31'h0, outs[idx]}, 32'h1);
    @(posedge core_clk_i);
  endtask

  // Longest wait is one full wrap of counter 1
  initial begin
    step(90000);
    miscompares++;
    end_of_test();
  end

  initial begin
    rstn_i = 1'b0; avs_address_i = 8'h00; avs_read_i = 1'b0; avs_write_i = 1'b0;
    avs_writedata_i = 32'h00000000; miscompares = 0; total_checks = 0; be = 4'hF;
    step(20);
    rstn_i <= 1'b1;
    step(1);
    rd_chk(CTRL_OFFSET, 32'h00000000);
    rd_chk(IRQ_STATUS_OFFSET, 32'h00000000);
    rd_chk(IRQ_MASK_OFFSET, 32'h00000000);
    wr(8'hA0, 8'h5A);
    rd_chk(8'hA0, 32'h00000000);
    wr(COUNT0_OFFSET, 8'hFF);
    rd_chk(COUNT0_OFFSET, 32'h00000000);
    wr(CTRL_OFFSET, 8'h10);
    bus(1'b0, COUNT0_OFFSET, 8'h00, c1);
    bus(1'b0, COUNT0_OFFSET, 8'h00, rd);
    cmp_word(rd - c1, 32'h00000003);
    rd_chk(COUNT1_OFFSET, 32'h00000000);
    wr(CTRL_OFFSET, 8'h00);
    bus(1'b0, COUNT0_OFFSET, 8'h00, c1);
    rd_chk(COUNT0_OFFSET, c1);
    wr(IRQ_MASK_OFFSET, 8'h03);
    rd_chk(IRQ_MASK_OFFSET, 32'h00000003);
    be <= 4'hE;
    wr(IRQ_MASK_OFFSET, 8'h0F);
    be <= 4'hF;
    rd_chk(IRQ_MASK_OFFSET, 32'h00000003);
    u_irq_partner.set_pin(0, 1'b0);
    wait_flag(0, 20);
    cmp_bit(4, 1'b1);
    u_irq_partner.pulse(0);
    cmp_bit(0, 1'b1);
    u_irq_partner.set_pin(0, 1'b1);
    step(5);
    u_irq_partner.pulse(0);
    cmp_bit(0, 1'b0);
    wr(CTRL_OFFSET, 8'h04);
    u_irq_partner.set_pin(1, 1'b0);
    wait_flag(1, 20);
    step(3);
    u_irq_partner.pulse(1);
    cmp_bit(1, 1'b0);
    cmp_bit(0, 1'b0);
    u_irq_partner.set_pin(1, 1'b1);
    rd_chk(IRQ_STATUS_OFFSET, 32'h00000003);
    cmp_bit(4, 1'b0);
    rd_chk(IRQ_STATUS_OFFSET, 32'h00000000);
    wr(CTRL_OFFSET, 8'h0F);
    rd_chk(CTRL_OFFSET, 32'h0000000D);
    wr(CTRL_OFFSET, 8'h0F);
    rd_chk(CTRL_OFFSET, 32'h0000000F);
    wr(CTRL_OFFSET, 8'h05);
    rd_chk(CTRL_OFFSET, 32'h00000005);
    wr(CTRL_OFFSET, 8'h00);
    wr(CTRL_OFFSET, 8'h02);
    rd_chk(CTRL_OFFSET, 32'h00000000);
    bus(1'b0, IRQ_STATUS_OFFSET, 8'h00, rd);
    wr(IRQ_MASK_OFFSET, 8'h0C);
    wr(CTRL_OFFSET, 8'h50);
    wait_flag(3, 70000);
    cmp_bit(2, 1'b1);
    cmp_bit(4, 1'b1);
    wr(CTRL_OFFSET, 8'hA0);
    rd_chk(IRQ_STATUS_OFFSET, 32'h0000000C);
    cmp_bit(4, 1'b0);
    u_irq_partner.pulse(2);
    cmp_bit(2, 1'b0);
    cmp_bit(3, 1'b1);
    u_irq_partner.pulse(3);
    cmp_bit(3, 1'b0);
    rd_chk(CTRL_OFFSET, 32'h00000000);
    end_of_test();
  end
endmodule
